// >>> occ_channel_config.v
// Purpose: Configuration bank and output stage of one clock channel
// Assumes: Register port driven from logic on clk
// Notes: All registers are 8 bits, read/write, reset to zero
//
// What this block does
// RULE1: The channel divide ratio is bits 3:0 of 0x48, then 0x49, then 0x4a, twenty bits in all.
// RULE2: Divide ratio bits 33:32 of the extended-range output come from bits 7:6 of the shared standard register.
// RULE3: The six low skew bits delay the output by 0 to 63 whole oscillator periods.
// RULE4: The two high skew bits add 0 to 3 fine steps of 30 ps.
// RULE5: A third fine bit at bit 4 of the shared standard register extends the fine code to 0 to 4 steps.
// RULE6: In single-ended drive the phase code routes true and complement clocks to the two pins.
// RULE7: Software should set the single-ended drive strength to seven.
// RULE8: Termination codes 0000, 0010 and 0001 give differential external, pull-up and pull-down.
// RULE9: Termination codes 0100, 1000 and 1100 drive the positive, the negative or both pins single-ended.
// RULE10: The three-bit standard code selects LVDS, LVPECL with current, CML, HCSL, boosted LVDS or LVPECL without.
// RULE11: The supply field at bits 4:3 of 0x4d declares 1.8, 2.5 or 3.3 volts.
// RULE12: Every bit is read/write, reads back what was written and resets to zero; spare bits do nothing.
// RULE13: Software should not write standard codes 110 or 111 nor supply code 11.
`timescale 1ns/1ps

`include "occ_defines.vh"

module occ_channel_config (
  input wire clk,
  input wire rst_n,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_rd_valid,
  output reg [19:0] output_divide_ratio,
  output reg [1:0] ext_divide_ratio_high,
  output reg [5:0] coarse_delay_periods,
  output reg [2:0] fine_delay_steps,
  output reg [7:0] fine_delay_ps,
  output reg [2:0] output_standard_select,
  output reg standard_lvds,
  output reg standard_lvpecl_cm,
  output reg standard_cml,
  output reg standard_hcsl,
  output reg standard_lvds_boost,
  output reg standard_lvpecl_nocm,
  output reg standard_valid,
  output reg [1:0] driver_supply_level,
  output reg supply_1v8,
  output reg supply_2v5,
  output reg supply_3v3,
  output reg supply_valid,
  output reg [2:0] se_drive_strength,
  output reg term_external,
  output reg term_pull_up,
  output reg term_pull_down,
  output reg single_ended_mode,
  output reg mode_valid,
  output wire internal_true_clock,
  output wire internal_complement_clock,
  output reg positive_pin_out,
  output reg positive_pin_oe,
  output reg negative_pin_out,
  output reg negative_pin_oe
);

  ////////////////////////////////////////////////////////////////
  // Functions

  // Fine code to step count, clamped at the largest step
  function [2:0] occ_fine_steps;
    input [2:0] code;
    begin
      if (code > `OCC_FINE_MAX_STEPS) begin
        occ_fine_steps = `OCC_FINE_MAX_STEPS;
      end else begin
        occ_fine_steps = code;
      end
    end
  endfunction

  // Phase code to pin levels, bit 1 positive and bit 0 negative
  function [1:0] occ_route;
    input [1:0] phase;
    input t;
    input c;
    begin
      case (phase)
        `OCC_PHASE_NORMAL: begin
          occ_route = {t, c};
        end
        `OCC_PHASE_TRUE_BOTH: begin
          occ_route = {t, t};
        end
        `OCC_PHASE_COMP_BOTH: begin
          occ_route = {c, c};
        end
        default: begin
          occ_route = {c, t};
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Reset release

  reg rst_meta_r;
  reg rst_sync_r;
  wire rst_sync_n;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_sync_n = rst_sync_r;

  ////////////////////////////////////////////////////////////////
  // Register storage

  reg [7:0] ch6_standard_and_extensions_r;
  reg [7:0] ch6_termination_mode_r;
  reg [7:0] ch7_divider_upper_bits_r;
  reg [7:0] ch7_divider_middle_byte_r;
  reg [7:0] ch7_divider_low_byte_r;
  reg [7:0] ch7_leg_phase_and_strength_r;
  reg [7:0] ch7_output_skew_r;
  reg [7:0] ch7_supply_level_select_r;
  reg [7:0] rdata_nxt;

  // RULE12: full byte stored
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ch6_standard_and_extensions_r <= `OCC_REG_RESET;
      ch6_termination_mode_r <= `OCC_REG_RESET;
      ch7_divider_upper_bits_r <= `OCC_REG_RESET;
      ch7_divider_middle_byte_r <= `OCC_REG_RESET;
      ch7_divider_low_byte_r <= `OCC_REG_RESET;
      ch7_leg_phase_and_strength_r <= `OCC_REG_RESET;
      ch7_output_skew_r <= `OCC_REG_RESET;
      ch7_supply_level_select_r <= `OCC_REG_RESET;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `OCC_ADDR_CH6_STD_EXT: begin
          ch6_standard_and_extensions_r <= reg_wdata;
        end
        `OCC_ADDR_CH6_TERM: begin
          ch6_termination_mode_r <= reg_wdata;
        end
        `OCC_ADDR_CH7_DIV_UP: begin
          ch7_divider_upper_bits_r <= reg_wdata;
        end
        `OCC_ADDR_CH7_DIV_MID: begin
          ch7_divider_middle_byte_r <= reg_wdata;
        end
        `OCC_ADDR_CH7_DIV_LOW: begin
          ch7_divider_low_byte_r <= reg_wdata;
        end
        `OCC_ADDR_CH7_PHASE: begin
          ch7_leg_phase_and_strength_r <= reg_wdata;
        end
        `OCC_ADDR_CH7_SKEW: begin
          ch7_output_skew_r <= reg_wdata;
        end
        `OCC_ADDR_CH7_SUPPLY: begin
          ch7_supply_level_select_r <= reg_wdata;
        end
        default: begin
          ch6_standard_and_extensions_r <= ch6_standard_and_extensions_r;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read back

  // RULE12: last value read back
  always @* begin
    case (reg_addr)
      `OCC_ADDR_CH6_STD_EXT: begin
        rdata_nxt = ch6_standard_and_extensions_r;
      end
      `OCC_ADDR_CH6_TERM: begin
        rdata_nxt = ch6_termination_mode_r;
      end
      `OCC_ADDR_CH7_DIV_UP: begin
        rdata_nxt = ch7_divider_upper_bits_r;
      end
      `OCC_ADDR_CH7_DIV_MID: begin
        rdata_nxt = ch7_divider_middle_byte_r;
      end
      `OCC_ADDR_CH7_DIV_LOW: begin
        rdata_nxt = ch7_divider_low_byte_r;
      end
      `OCC_ADDR_CH7_PHASE: begin
        rdata_nxt = ch7_leg_phase_and_strength_r;
      end
      `OCC_ADDR_CH7_SKEW: begin
        rdata_nxt = ch7_output_skew_r;
      end
      `OCC_ADDR_CH7_SUPPLY: begin
        rdata_nxt = ch7_supply_level_select_r;
      end
      default: begin
        rdata_nxt = `OCC_UNMAPPED_READ;
      end
    endcase
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Field extraction

  wire [19:0] ratio_w;
  wire [2:0] fine_code_w;
  wire [2:0] std_w;
  wire [1:0] supply_w;
  wire [3:0] term_w;
  wire [1:0] phase_w;
  wire [1:0] pins_w;

  // RULE1: ratio assembly
  assign ratio_w = {ch7_divider_upper_bits_r[`OCC_DIV_UP_MSB:0], ch7_divider_middle_byte_r,
    ch7_divider_low_byte_r};
  // RULE5: third fine bit
  assign fine_code_w = {ch6_standard_and_extensions_r[`OCC_EXT_FINE_BIT],
    ch7_output_skew_r[`OCC_FINE_MSB:`OCC_FINE_LSB]};
  assign std_w = ch6_standard_and_extensions_r[`OCC_STD_MSB:`OCC_STD_LSB];
  assign supply_w = ch7_supply_level_select_r[`OCC_SUPPLY_MSB:`OCC_SUPPLY_LSB];
  assign term_w = ch6_termination_mode_r[`OCC_TERM_MSB:`OCC_TERM_LSB];
  assign phase_w = ch7_leg_phase_and_strength_r[`OCC_PHASE_MSB:`OCC_PHASE_LSB];

  ////////////////////////////////////////////////////////////////
  // Divider and delay line

  wire true_clk_w;
  wire comp_clk_w;

  occ_div_delay u_div_delay (
    .clk(clk),
    .rst_sync_n(rst_sync_n),
    .ratio(ratio_w),
    .coarse(ch7_output_skew_r[`OCC_COARSE_MSB:`OCC_COARSE_LSB]),
    .div_clk_r(),
    .true_clk_r(true_clk_w),
    .comp_clk_r(comp_clk_w)
  );

  assign internal_true_clock = true_clk_w;
  assign internal_complement_clock = comp_clk_w;
  // RULE6: phase routing
  assign pins_w = occ_route(phase_w, true_clk_w, comp_clk_w);

  ////////////////////////////////////////////////////////////////
  // Decoded settings

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      output_divide_ratio <= 20'h00000;
      ext_divide_ratio_high <= 2'h0;
      coarse_delay_periods <= 6'h00;
      fine_delay_steps <= 3'h0;
      fine_delay_ps <= 8'h00;
      output_standard_select <= 3'h0;
      standard_lvds <= 1'b0;
      standard_lvpecl_cm <= 1'b0;
      standard_cml <= 1'b0;
      standard_hcsl <= 1'b0;
      standard_lvds_boost <= 1'b0;
      standard_lvpecl_nocm <= 1'b0;
      standard_valid <= 1'b0;
      driver_supply_level <= 2'h0;
      supply_1v8 <= 1'b0;
      supply_2v5 <= 1'b0;
      supply_3v3 <= 1'b0;
      supply_valid <= 1'b0;
      se_drive_strength <= 3'h0;
    end else begin
      output_divide_ratio <= ratio_w;
      // RULE2: extended ratio bits
      ext_divide_ratio_high <= ch6_standard_and_extensions_r[`OCC_EXT_DIV_MSB:`OCC_EXT_DIV_LSB];
      // RULE3: coarse periods
      coarse_delay_periods <= ch7_output_skew_r[`OCC_COARSE_MSB:`OCC_COARSE_LSB];
      // RULE4: fine step count
      fine_delay_steps <= occ_fine_steps(fine_code_w);
      fine_delay_ps <= {5'h00, occ_fine_steps(fine_code_w)} * `OCC_FINE_STEP_PS;
      // RULE10: standard decode
      output_standard_select <= std_w;
      standard_lvds <= (std_w == `OCC_STD_LVDS);
      standard_lvpecl_cm <= (std_w == `OCC_STD_LVPECL_CM);
      standard_cml <= (std_w == `OCC_STD_CML);
      standard_hcsl <= (std_w == `OCC_STD_HCSL);
      standard_lvds_boost <= (std_w == `OCC_STD_LVDS_BOOST);
      standard_lvpecl_nocm <= (std_w == `OCC_STD_LVPECL_NOCM);
      standard_valid <= (std_w <= `OCC_STD_LVPECL_NOCM);
      // RULE11: supply decode
      driver_supply_level <= supply_w;
      supply_1v8 <= (supply_w == `OCC_SUPPLY_1V8);
      supply_2v5 <= (supply_w == `OCC_SUPPLY_2V5);
      supply_3v3 <= (supply_w == `OCC_SUPPLY_3V3);
      supply_valid <= (supply_w != 2'h3);
      se_drive_strength <= ch7_leg_phase_and_strength_r[`OCC_STRENGTH_MSB:`OCC_STRENGTH_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Termination, mode and pin drive

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      term_external <= 1'b0;
      term_pull_up <= 1'b0;
      term_pull_down <= 1'b0;
      single_ended_mode <= 1'b0;
      mode_valid <= 1'b0;
      positive_pin_out <= 1'b0;
      positive_pin_oe <= 1'b0;
      negative_pin_out <= 1'b0;
      negative_pin_oe <= 1'b0;
    end else begin
      term_external <= (term_w == `OCC_TERM_EXTERNAL);
      term_pull_up <= (term_w == `OCC_TERM_PULL_UP);
      term_pull_down <= (term_w == `OCC_TERM_PULL_DOWN);
      case (term_w)
        // RULE8: differential drive
        `OCC_TERM_EXTERNAL, `OCC_TERM_PULL_UP, `OCC_TERM_PULL_DOWN: begin
          single_ended_mode <= 1'b0;
          mode_valid <= 1'b1;
          positive_pin_out <= true_clk_w;
          positive_pin_oe <= 1'b1;
          negative_pin_out <= comp_clk_w;
          negative_pin_oe <= 1'b1;
        end
        // RULE9: single-ended positive
        `OCC_TERM_SE_POS: begin
          single_ended_mode <= 1'b1;
          mode_valid <= 1'b1;
          positive_pin_out <= pins_w[1];
          positive_pin_oe <= 1'b1;
          negative_pin_out <= 1'b0;
          negative_pin_oe <= 1'b0;
        end
        // RULE9: single-ended negative
        `OCC_TERM_SE_NEG: begin
          single_ended_mode <= 1'b1;
          mode_valid <= 1'b1;
          positive_pin_out <= 1'b0;
          positive_pin_oe <= 1'b0;
          negative_pin_out <= pins_w[0];
          negative_pin_oe <= 1'b1;
        end
        // RULE9: single-ended both
        `OCC_TERM_SE_BOTH: begin
          single_ended_mode <= 1'b1;
          mode_valid <= 1'b1;
          positive_pin_out <= pins_w[1];
          positive_pin_oe <= 1'b1;
          negative_pin_out <= pins_w[0];
          negative_pin_oe <= 1'b1;
        end
        default: begin
          single_ended_mode <= 1'b0;
          mode_valid <= 1'b0;
          positive_pin_out <= 1'b0;
          positive_pin_oe <= 1'b0;
          negative_pin_out <= 1'b0;
          negative_pin_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule // occ_channel_config

// >>> occ_channel_props.sv
// Purpose: Port-level checks for the channel configuration bank
// Assumes: Single clk domain, rst_n released through two flops inside
// Notes: Checks start four edges after rst_n rises
`timescale 1ns/1ps

module occ_channel_props (
  input wire clk,
  input wire rst_n,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire reg_rd_valid,
  input wire [19:0] output_divide_ratio,
  input wire [5:0] coarse_delay_periods,
  input wire [2:0] fine_delay_steps,
  input wire [7:0] fine_delay_ps,
  input wire [2:0] output_standard_select,
  input wire standard_valid,
  input wire [1:0] driver_supply_level,
  input wire supply_valid,
  input wire single_ended_mode,
  input wire mode_valid,
  input wire positive_pin_oe,
  input wire negative_pin_oe
);
  reg [2:0] live_cnt_r;
  wire live = (live_cnt_r == 3'h4);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live_cnt_r <= 3'h0;
    end else if (!live) begin
      live_cnt_r <= live_cnt_r + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !live);

  ////////////////////////////////////////////////////////////////////////////////
  chk_rd_valid_pulse: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read not answered next cycle");
  chk_no_stray_valid: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("read valid without a read");
  chk_rdata_hold: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  chk_ratio_low_byte: assert property ((reg_wr_en && reg_addr == 8'h4a) |-> ##2
    output_divide_ratio[7:0] == $past(reg_wdata, 2))
    else $error("low ratio byte not applied");
  chk_coarse_skew: assert property ((reg_wr_en && reg_addr == 8'h4c) |-> ##2
    coarse_delay_periods == $past(reg_wdata[5:0], 2))
    else $error("coarse delay not applied");
  chk_fine_steps: assert property (fine_delay_steps <= 3'h4 && fine_delay_ps == fine_delay_steps * 8'd30)
    else $error("fine delay out of range");
  chk_std_valid: assert property (standard_valid == (output_standard_select <= 3'h5))
    else $error("standard valid flag wrong");
  chk_supply_valid: assert property (supply_valid == (driver_supply_level != 2'h3))
    else $error("supply valid flag wrong");
  chk_diff_oe_both: assert property ((mode_valid && !single_ended_mode) [*2] |->
    positive_pin_oe && negative_pin_oe)
    else $error("differential mode not driving both pins");
endmodule // occ_channel_props

bind occ_channel_config occ_channel_props u_props (.clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .output_divide_ratio(output_divide_ratio),
  .coarse_delay_periods(coarse_delay_periods), .fine_delay_steps(fine_delay_steps),
  .fine_delay_ps(fine_delay_ps), .output_standard_select(output_standard_select),
  .standard_valid(standard_valid), .driver_supply_level(driver_supply_level),
  .supply_valid(supply_valid), .single_ended_mode(single_ended_mode), .mode_valid(mode_valid),
  .positive_pin_oe(positive_pin_oe), .negative_pin_oe(negative_pin_oe));

// >>> occ_defines.vh
// Purpose: Constants for the output clock channel configuration bank
// Assumes: 8-bit register port, one 40 MHz clock
// Notes: Offsets are the byte addresses of the register port
`ifndef OCC_DEFINES_VH
`define OCC_DEFINES_VH

// Register offsets
`define OCC_ADDR_CH6_STD_EXT 8'h46
`define OCC_ADDR_CH6_TERM 8'h47
`define OCC_ADDR_CH7_DIV_UP 8'h48
`define OCC_ADDR_CH7_DIV_MID 8'h49
`define OCC_ADDR_CH7_DIV_LOW 8'h4a
`define OCC_ADDR_CH7_PHASE 8'h4b
`define OCC_ADDR_CH7_SKEW 8'h4c
`define OCC_ADDR_CH7_SUPPLY 8'h4d

// Reset value of every register
`define OCC_REG_RESET 8'h00
// Read value of an unmapped offset
`define OCC_UNMAPPED_READ 8'h00

// Field positions
`define OCC_DIV_UP_MSB 3
`define OCC_EXT_DIV_MSB 7
`define OCC_EXT_DIV_LSB 6
`define OCC_EXT_FINE_BIT 4
`define OCC_STD_MSB 2
`define OCC_STD_LSB 0
`define OCC_TERM_MSB 3
`define OCC_TERM_LSB 0
`define OCC_PHASE_MSB 7
`define OCC_PHASE_LSB 6
`define OCC_STRENGTH_MSB 2
`define OCC_STRENGTH_LSB 0
`define OCC_COARSE_MSB 5
`define OCC_COARSE_LSB 0
`define OCC_FINE_MSB 7
`define OCC_FINE_LSB 6
`define OCC_SUPPLY_MSB 4
`define OCC_SUPPLY_LSB 3

// Output standard codes
`define OCC_STD_LVDS 3'h0
`define OCC_STD_LVPECL_CM 3'h1
`define OCC_STD_CML 3'h2
`define OCC_STD_HCSL 3'h3
`define OCC_STD_LVDS_BOOST 3'h4
`define OCC_STD_LVPECL_NOCM 3'h5

// Supply level codes
`define OCC_SUPPLY_1V8 2'h0
`define OCC_SUPPLY_2V5 2'h1
`define OCC_SUPPLY_3V3 2'h2

// Termination and mode codes
`define OCC_TERM_EXTERNAL 4'h0
`define OCC_TERM_PULL_UP 4'h2
`define OCC_TERM_PULL_DOWN 4'h1
`define OCC_TERM_SE_POS 4'h4
`define OCC_TERM_SE_NEG 4'h8
`define OCC_TERM_SE_BOTH 4'hc

// Phase codes
`define OCC_PHASE_NORMAL 2'h0
`define OCC_PHASE_TRUE_BOTH 2'h1
`define OCC_PHASE_COMP_BOTH 2'h2
`define OCC_PHASE_SWAP 2'h3

// Timing
`define OCC_FINE_STEP_PS 8'h1e
`define OCC_FINE_MAX_STEPS 3'h4
`define OCC_COARSE_TAPS 63
`define OCC_DIV_MIN 20'h00002

`endif

// >>> occ_div_delay.v
// Purpose: Output divider and coarse delay line for one channel
// Assumes: clk stands in for the oscillator clock
// Notes: Ratios below two divide by two
`timescale 1ns/1ps

`include "occ_defines.vh"

module occ_div_delay (
  input wire clk,
  input wire rst_sync_n,
  input wire [19:0] ratio,
  input wire [5:0] coarse,
  output reg div_clk_r,
  output reg true_clk_r,
  output reg comp_clk_r
);

  wire [19:0] div_n;
  wire [19:0] half_n;
  wire [19:0] last_n;
  reg [19:0] count_r;
  reg [19:0] count_nxt;
  reg [62:0] dly_r;
  reg tap;

  assign div_n = (ratio < `OCC_DIV_MIN) ? `OCC_DIV_MIN : ratio;
  assign half_n = {1'b0, div_n[19:1]};
  assign last_n = div_n - 20'h00001;

  ////////////////////////////////////////////////////////////////
  // Divider
  // RULE1: divide by ratio
  always @* begin
    if (count_r >= last_n) begin
      count_nxt = 20'h00000;
    end else begin
      count_nxt = count_r + 20'h00001;
    end
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_r <= 20'h00000;
      div_clk_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      div_clk_r <= (count_nxt < half_n);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Coarse delay line
  // RULE3: tap per period
  always @* begin
    if (coarse == 6'h00) begin
      tap = div_clk_r;
    end else begin
      tap = dly_r[coarse - 6'h01];
    end
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dly_r <= 63'h0;
      true_clk_r <= 1'b0;
      comp_clk_r <= 1'b1;
    end else begin
      dly_r <= {dly_r[61:0], div_clk_r};
      true_clk_r <= tap;
      comp_clk_r <= ~tap;
    end
  end

endmodule // occ_div_delay

// >>> output_clock_channel_config_bench.sv
// Purpose: Self-checking bench for the channel configuration bank
// Assumes: 40 MHz clk, register port driven on rising edges
// Notes: Expectations come from the field layout only
`timescale 1ns/1ps

`include "occ_defines.vh"

module output_clock_channel_config_bench;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg reg_wr_en = 1'b0;
  reg reg_rd_en = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire reg_rd_valid;
  wire [19:0] output_divide_ratio;
  wire [1:0] ext_divide_ratio_high;
  wire [5:0] coarse_delay_periods;
  wire [2:0] fine_delay_steps;
  wire [7:0] fine_delay_ps;
  wire [2:0] output_standard_select;
  wire [5:0] std_vec;
  wire standard_valid;
  wire [1:0] driver_supply_level;
  wire [2:0] sup_vec;
  wire supply_valid;
  wire [2:0] se_drive_strength;
  wire term_external, term_pull_up, term_pull_down, single_ended_mode, mode_valid;
  wire internal_true_clock, internal_complement_clock;
  wire positive_pin_out, positive_pin_oe, negative_pin_out, negative_pin_oe;
  integer error_cnt = 0;
  integer total_checks = 0;
  integer cyc = 0;
  integer i;
  integer t0, t1, t2;

  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  occ_channel_config DUT (.clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .output_divide_ratio(output_divide_ratio), .ext_divide_ratio_high(ext_divide_ratio_high),
    .coarse_delay_periods(coarse_delay_periods), .fine_delay_steps(fine_delay_steps),
    .fine_delay_ps(fine_delay_ps), .output_standard_select(output_standard_select),
    .standard_lvds(std_vec[5]), .standard_lvpecl_cm(std_vec[4]), .standard_cml(std_vec[3]),
    .standard_hcsl(std_vec[2]), .standard_lvds_boost(std_vec[1]), .standard_lvpecl_nocm(std_vec[0]),
    .standard_valid(standard_valid), .driver_supply_level(driver_supply_level),
    .supply_1v8(sup_vec[2]), .supply_2v5(sup_vec[1]), .supply_3v3(sup_vec[0]), .supply_valid(supply_valid),
    .se_drive_strength(se_drive_strength), .term_external(term_external), .term_pull_up(term_pull_up),
    .term_pull_down(term_pull_down), .single_ended_mode(single_ended_mode), .mode_valid(mode_valid),
    .internal_true_clock(internal_true_clock), .internal_complement_clock(internal_complement_clock),
    .positive_pin_out(positive_pin_out), .positive_pin_oe(positive_pin_oe),
    .negative_pin_out(negative_pin_out), .negative_pin_oe(negative_pin_oe));

  ////////////////////////////////////////////////////////////////////////////////
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value %0s expected %0h seen %0h", name, exp, seen);
      end
    end
  endtask

  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask

  task apply_reset;
    begin
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_rd_en <= 1'b0;
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
    end
  endtask

  task wr_settle(input [7:0] a, input [7:0] d);
    begin
      wr(a, d);
      @(posedge clk);
      reg_wr_en <= 1'b0;
      @(posedge clk);
      #1;
    end
  endtask

  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      #1;
      check("rd_valid", reg_rd_valid, 1'b1);
      check("rdata", reg_rdata, exp);
    end
  endtask

  task find_rise(output integer t);
    reg prev;
    integer n;
    begin
      #1;
      prev = internal_true_clock;
      t = -1;
      for (n = 0; n < 40 && t < 0; n = n + 1) begin
        @(posedge clk);
        #1;
        if (prev === 1'b0 && internal_true_clock === 1'b1) t = cyc;
        prev = internal_true_clock;
      end
      if (t < 0) begin
        check("rise_timeout", 1, 0);
        give_verdict;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task test_reset_values;
    begin
      check("defaults", {term_external, std_vec[5], standard_valid, sup_vec[2], mode_valid}, 5'h1f);
      for (i = 8'h44; i <= 8'h4f; i = i + 1) rd(i, 8'h00);
    end
  endtask

  task test_read_write;
    begin
      for (i = 0; i < 8; i = i + 1) wr(`OCC_ADDR_CH6_STD_EXT + i, 8'h11 * i + 8'h80);
      for (i = 0; i < 8; i = i + 1) rd(`OCC_ADDR_CH6_STD_EXT + i, 8'h11 * i + 8'h80);
      wr(8'h50, 8'hff);
      rd(8'h50, `OCC_UNMAPPED_READ);
      apply_reset;
      rd(`OCC_ADDR_CH7_SKEW, 8'h00);
    end
  endtask

  task test_divider;
    begin
      wr(`OCC_ADDR_CH7_DIV_UP, 8'hf9);
      wr(`OCC_ADDR_CH7_DIV_MID, 8'h3c);
      wr_settle(`OCC_ADDR_CH7_DIV_LOW, 8'h81);
      check("ratio", output_divide_ratio, 20'h93c81);
      wr_settle(`OCC_ADDR_CH6_STD_EXT, 8'h80);
      check("ext_ratio", ext_divide_ratio_high, 2'h2);
      wr_settle(`OCC_ADDR_CH6_STD_EXT, 8'h40);
      check("ext_ratio", ext_divide_ratio_high, 2'h1);
    end
  endtask

  task test_skew_codes;
    integer s;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        wr(`OCC_ADDR_CH6_STD_EXT, {3'h0, i[2], 4'h0});
        wr_settle(`OCC_ADDR_CH7_SKEW, {i[1:0], 6'h2a + i[5:0]});
        s = (i > 4) ? 4 : i;
        check("coarse", coarse_delay_periods, 6'h2a + i);
        check("fine_steps", fine_delay_steps, s);
        check("fine_ps", fine_delay_ps, s * `OCC_FINE_STEP_PS);
      end
    end
  endtask

  task test_standard_supply;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        wr_settle(`OCC_ADDR_CH6_STD_EXT, i);
        check("std_sel", output_standard_select, i);
        check("std_vec", std_vec, (i < 6) ? (6'h20 >> i) : 6'h00);
        check("std_valid", standard_valid, i < 6);
      end
      for (i = 0; i < 3; i = i + 1) begin
        wr_settle(`OCC_ADDR_CH7_SUPPLY, i << 3);
        check("supply", driver_supply_level, i);
        check("sup_vec", {sup_vec, supply_valid}, (i < 3) ? {3'h4 >> i, 1'b1} : 4'h0);
      end
    end
  endtask

  task test_termination;
    reg se;
    reg mv;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        wr_settle(`OCC_ADDR_CH6_TERM, i);
        se = (i == 4 || i == 8 || i == 12);
        mv = se || i < 3;
        check("term", {term_external, term_pull_up, term_pull_down}, {i == 0, i == 2, i == 1});
        check("mode", {single_ended_mode, mode_valid}, {se, mv});
        check("oe", {positive_pin_oe, negative_pin_oe}, {mv && i != 8, mv && i != 4});
      end
    end
  endtask

  task test_phase_routing;
    reg pt;
    reg pc;
    integer n;
    begin
      wr(`OCC_ADDR_CH7_DIV_UP, 8'h00);
      wr(`OCC_ADDR_CH7_DIV_MID, 8'h00);
      wr(`OCC_ADDR_CH7_DIV_LOW, 8'h04);
      for (i = 0; i < 5; i = i + 1) begin
        wr(`OCC_ADDR_CH6_TERM, (i < 4) ? 8'h0c : 8'h00);
        wr_settle(`OCC_ADDR_CH7_PHASE, {i[1:0] | {2{i[2]}}, 6'h07});
        check("strength", se_drive_strength, 3'h7);
        for (n = 0; n < 12; n = n + 1) begin
          pt = internal_true_clock;
          pc = internal_complement_clock;
          @(posedge clk);
          #1;
          check("pos_pin", positive_pin_out, (i < 4 && i[1]) ? pc : pt);
          check("neg_pin", negative_pin_out, (i == 4 || !i[0]) ? pc : pt);
          check("comp_clk", pc, !pt);
        end
      end
    end
  endtask

  task test_coarse_delay;
    begin
      wr(`OCC_ADDR_CH7_DIV_LOW, 8'h08);
      wr_settle(`OCC_ADDR_CH7_SKEW, 8'h00);
      repeat (20) @(posedge clk);
      find_rise(t0);
      wr_settle(`OCC_ADDR_CH7_SKEW, 8'h03);
      repeat (20) @(posedge clk);
      find_rise(t1);
      find_rise(t2);
      check("coarse_shift", (t1 - t0) % 8, 3);
      check("period", t2 - t1, 8);
    end
  endtask

  initial begin
    apply_reset;
    test_reset_values;
    test_read_write;
    test_divider;
    test_skew_codes;
    test_standard_supply;
    test_termination;
    test_phase_routing;
    test_coarse_delay;
    give_verdict;
  end
endmodule // output_clock_channel_config_bench
